// File: psd_top.sv
// Operation
// - half duplex: carrier on transmit or receive
// - half duplex: receive during transmit is collision
// - full duplex: carrier follows receive only
// - full duplex: collision never asserted
// - detect partner pairs, map own pairs
// - register bit disables automatic crossover
// - sample regulator strap once supplies valid
// - floating regulator strap reads low, regulator on
// - latch function strap at reset release
// - strap high: interrupt out; low: transmit error
// - latch 5-bit address at reset release
// - floating address pin one, pulled-down zero
// - address bit high: led active low
// - address bit low: led active high
// - autoneg off: duplex, speed from control bits
`include "psd_defs.svh"

module psd_top #(
    parameter int MDIX_SLOT_CYC = `PSD_MDIX_SLOT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // strap pins as seen (pull resolved)
    input wire psd_pkg::psd_led_t led_pin_i,
    input wire logic crs_pin_i,
    input wire logic shared_pin_function_strap_i,
    input wire logic regulator_off_strap_pin_i,
    input wire logic supplies_ok_i,
    // negotiated result and line activity
    input wire logic an_full_duplex_i,
    input wire logic an_speed_100_i,
    input wire logic tx_active_i,
    input wire logic rx_active_i,
    input wire logic rx_energy_i,
    input wire logic irq_i,
    input wire logic shared_pin_i,
    input wire psd_pkg::psd_led_t led_active_i,
    // outputs
    output psd_pkg::psd_led_t led_o,
    output psd_pkg::psd_led_t led_oe_o,
    output logic crs_o,
    output logic crs_oe_o,
    output logic col_o,
    output logic interrupt_output_low_o,
    output logic shared_oe_o,
    output logic transmit_symbol_bit_four_o,
    output logic regulator_off_o,
    output psd_pkg::psd_addr_t mgmt_addr_o,
    output logic full_duplex_o,
    output logic speed_100_o,
    output logic tx_pair_swap_o,
    output logic straps_done_o
);
    import psd_pkg::*;

    ////////////////////////////////////////////////////////////////
    // helpers

    // byte-lane merge of a write into a register
    function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // led pin level from internal state and strap-chosen polarity
    function automatic psd_led_t led_drive(input psd_led_t act, input psd_led_t pol_low);
        return act ^ pol_low;
    endfunction

    ////////////////////////////////////////////////////////////////
    // declarations
    logic rst_q; // reset one cycle ago
    logic strap_cap; // first cycle after reset release
    psd_addr_t addr_reg; // latched management address
    logic intsel_reg; // latched pin function select
    logic regoff_reg; // latched regulator-off strap
    logic regoff_done_reg; // regulator strap sampled
    logic [31:0] ctrl_reg; // control register
    logic [31:0] mdix_reg; // crossover control register
    logic [31:0] status_v; // status read view
    logic mdix_locked; // crossover locked on partner
    logic wb_req; // new bus request this cycle

    assign strap_cap = rst_q && !rst_i;
    assign wb_req = cyc_i && stb_i && !ack_o;

    ////////////////////////////////////////////////////////////////
    // strap capture on reset release; regulator strap once supplies valid

    // reset history, sampled every cycle
    always_ff @(posedge clk_i) begin
        rst_q <= rst_i;
    end

    // address and function straps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= `PSD_ADDR_RESET;
            intsel_reg <= `PSD_INTSEL_RESET;
        end else if (strap_cap) begin
            addr_reg <= {crs_pin_i, led_pin_i};
            intsel_reg <= shared_pin_function_strap_i;
        end
    end

    // regulator strap, once after supplies are valid
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regoff_reg <= `PSD_REGOFF_RESET;
            regoff_done_reg <= 1'b0;
        end else if (supplies_ok_i && !regoff_done_reg) begin
            regoff_reg <= regulator_off_strap_pin_i;
            regoff_done_reg <= 1'b1;
        end
    end

    // strap values to the pins' owners
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            straps_done_o <= 1'b0;
            mgmt_addr_o <= `PSD_ADDR_RESET;
            regulator_off_o <= `PSD_REGOFF_RESET;
        end else begin
            if (strap_cap) begin
                straps_done_o <= 1'b1;
            end
            mgmt_addr_o <= addr_reg;
            regulator_off_o <= regoff_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // wishbone slave

    // register writes, lane by lane
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `PSD_CTRL_RESET;
            mdix_reg <= `PSD_MDIX_RESET;
        end else if (wb_req && we_i) begin
            if (adr_i == `PSD_CTRL_OFS) begin
                ctrl_reg <= wb_merge(ctrl_reg, dat_i, sel_i);
            end else if (adr_i == `PSD_MDIX_OFS) begin
                mdix_reg <= wb_merge(mdix_reg, dat_i, sel_i);
            end
        end
    end

    // status view of the block's own state
    always_comb begin
        status_v = 32'h0000_0000;
        status_v[`PSD_ST_ADDR_LSB +: 5] = addr_reg;
        status_v[`PSD_ST_INTSEL_BIT] = intsel_reg;
        status_v[`PSD_ST_REGOFF_BIT] = regoff_reg;
        status_v[`PSD_ST_FULL_BIT] = full_duplex_o;
        status_v[`PSD_ST_SPEED_BIT] = speed_100_o;
        status_v[`PSD_ST_SWAP_BIT] = tx_pair_swap_o;
        status_v[`PSD_ST_LOCK_BIT] = mdix_locked;
    end

    // one-cycle ack, read data latched with it; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wb_req;
            if (wb_req && !we_i) begin
                case (adr_i)
                    `PSD_CTRL_OFS: dat_o <= ctrl_reg;
                    `PSD_STATUS_OFS: dat_o <= status_v;
                    `PSD_MDIX_OFS: dat_o <= mdix_reg;
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // operating mode

    // negotiated or forced duplex and speed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            full_duplex_o <= 1'b0;
            speed_100_o <= 1'b0;
        end else if (ctrl_reg[`PSD_CTRL_AN_EN_BIT]) begin
            full_duplex_o <= an_full_duplex_i;
            speed_100_o <= an_speed_100_i;
        end else begin
            full_duplex_o <= ctrl_reg[`PSD_CTRL_DUPLEX_BIT];
            speed_100_o <= ctrl_reg[`PSD_CTRL_SPEED_BIT];
        end
    end

    // carrier sense and collision
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crs_o <= 1'b0;
            col_o <= 1'b0;
        end else if (full_duplex_o) begin
            crs_o <= rx_active_i;
            col_o <= 1'b0;
        end else begin
            crs_o <= tx_active_i || rx_active_i;
            col_o <= tx_active_i && rx_active_i;
        end
    end

    ////////////////////////////////////////////////////////////////
    // strap-shared pins: released while straps are read

    // led polarity from address straps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_o <= 4'h0;
            led_oe_o <= 4'h0;
            crs_oe_o <= 1'b0;
        end else begin
            led_o <= led_drive(led_active_i, addr_reg[3:0]);
            led_oe_o <= {4{straps_done_o}};
            crs_oe_o <= straps_done_o;
        end
    end

    // shared interrupt / transmit error pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            interrupt_output_low_o <= 1'b1;
            shared_oe_o <= 1'b0;
            transmit_symbol_bit_four_o <= 1'b0;
        end else begin
            interrupt_output_low_o <= !irq_i;
            shared_oe_o <= straps_done_o && intsel_reg;
            transmit_symbol_bit_four_o <= straps_done_o && !intsel_reg && shared_pin_i;
        end
    end

    ////////////////////////////////////////////////////////////////
    // crossover
    psd_mdix #(
        .SLOT_CYC(MDIX_SLOT_CYC)
    ) psd_mdix_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .auto_en_i(!mdix_reg[`PSD_MDIX_DIS_BIT]),
        .force_swap_i(mdix_reg[`PSD_MDIX_FORCE_BIT]),
        .rx_energy_i(rx_energy_i),
        .swap_o(tx_pair_swap_o),
        .locked_o(mdix_locked)
    );

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_crs_half;
        (!full_duplex_o && (tx_active_i || rx_active_i)) |=> crs_o;
    endproperty
    a_crs_half: assert property (p_crs_half) else $error("no carrier in half duplex");

    property p_col_half;
        (!full_duplex_o && tx_active_i && rx_active_i) |=> col_o;
    endproperty
    a_col_half: assert property (p_col_half) else $error("no collision in half duplex");

    property p_crs_full;
        full_duplex_o |=> (crs_o == $past(rx_active_i));
    endproperty
    a_crs_full: assert property (p_crs_full) else $error("carrier not from receive");

    property p_col_full;
        full_duplex_o |=> !col_o;
    endproperty
    a_col_full: assert property (p_col_full) else $error("collision in full duplex");

    property p_mdix_forced;
        (mdix_reg[`PSD_MDIX_DIS_BIT] && mdix_reg[`PSD_MDIX_FORCE_BIT]) [*2] |=> tx_pair_swap_o;
    endproperty
    a_mdix_forced: assert property (p_mdix_forced) else $error("forced map ignored");

    property p_regoff;
        (supplies_ok_i && !regoff_done_reg) |=> (regoff_reg == $past(regulator_off_strap_pin_i));
    endproperty
    a_regoff: assert property (p_regoff) else $error("regulator strap not sampled");

    sequence s_release;
        strap_cap;
    endsequence

    property p_addr_latch;
        s_release |=> (addr_reg == $past({crs_pin_i, led_pin_i}));
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

    property p_strap_hold;
        !strap_cap |=> ($stable(addr_reg) && $stable(intsel_reg));
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed while running");

    property p_shared_mode;
        s_release ##1 1'b1 |=> (shared_oe_o == $past(intsel_reg));
    endproperty
    a_shared_mode: assert property (p_shared_mode) else $error("shared pin mode wrong");

    property p_led_low;
        (straps_done_o && addr_reg[0] && led_active_i[0]) |=> !led_o[0];
    endproperty
    a_led_low: assert property (p_led_low) else $error("led not active low");

    property p_led_high;
        (straps_done_o && !addr_reg[0] && led_active_i[0]) |=> led_o[0];
    endproperty
    a_led_high: assert property (p_led_high) else $error("led not active high");

    property p_forced_speed;
        !ctrl_reg[`PSD_CTRL_AN_EN_BIT] |=> (speed_100_o == $past(ctrl_reg[`PSD_CTRL_SPEED_BIT])
            && full_duplex_o == $past(ctrl_reg[`PSD_CTRL_DUPLEX_BIT]));
    endproperty
    a_forced_speed: assert property (p_forced_speed) else $error("forced mode ignored");
endmodule

// File: psd_defs.svh
`ifndef PSD_DEFS_SVH
`define PSD_DEFS_SVH

// register byte offsets
`define PSD_CTRL_OFS 4'h0
`define PSD_STATUS_OFS 4'h4
`define PSD_MDIX_OFS 4'h8

// control register fields
`define PSD_CTRL_DUPLEX_BIT 8
`define PSD_CTRL_AN_EN_BIT 12
`define PSD_CTRL_SPEED_BIT 13
`define PSD_CTRL_RESET 32'h0000_3000

// crossover control fields
`define PSD_MDIX_DIS_BIT 0
`define PSD_MDIX_FORCE_BIT 1
`define PSD_MDIX_RESET 32'h0000_0000

// status register fields
`define PSD_ST_ADDR_LSB 0
`define PSD_ST_INTSEL_BIT 5
`define PSD_ST_REGOFF_BIT 6
`define PSD_ST_FULL_BIT 7
`define PSD_ST_SPEED_BIT 8
`define PSD_ST_SWAP_BIT 9
`define PSD_ST_LOCK_BIT 10

// strap defaults: pulled-up address, pulled-up function select, pulled-down regulator strap
`define PSD_ADDR_RESET 5'h1f
`define PSD_INTSEL_RESET 1'h1
`define PSD_REGOFF_RESET 1'h0

// timing
`define PSD_CLK_PERIOD_NS 10
`define PSD_MDIX_SLOT_NS 100000
`define PSD_MDIX_SLOT_CYC (`PSD_MDIX_SLOT_NS / `PSD_CLK_PERIOD_NS)

`endif

// File: psd_pkg.sv
package psd_pkg;
    // crossover state, gray along hunt -> lock, forced off the path
    typedef enum logic [1:0] {
        PSD_MDIX_HUNT = 2'h0,
        PSD_MDIX_LOCK = 2'h1,
        PSD_MDIX_FORCED = 2'h3
    } psd_mdix_state_e;
    // management address
    typedef logic [4:0] psd_addr_t;
    // led lane group
    typedef logic [3:0] psd_led_t;
endpackage

// File: psd_mdix.sv
`include "psd_defs.svh"

module psd_mdix #(
    parameter int SLOT_CYC = `PSD_MDIX_SLOT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic auto_en_i,
    input wire logic force_swap_i,
    input wire logic rx_energy_i,
    output logic swap_o,
    output logic locked_o
);
    import psd_pkg::*;

    localparam int CW = $clog2(SLOT_CYC);

    psd_mdix_state_e state_reg; // crossover state
    logic [CW-1:0] cnt_reg; // hunting slot timer
    logic slot_end; // slot timer expired

    assign slot_end = (cnt_reg == CW'(SLOT_CYC - 1));

    ////////////////////////////////////////////////////////////////
    // state: hunt for partner energy, lock on it, or stay forced
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= PSD_MDIX_HUNT;
        end else begin
            case (state_reg)
                PSD_MDIX_HUNT: begin
                    if (!auto_en_i) begin
                        state_reg <= PSD_MDIX_FORCED;
                    end else if (rx_energy_i) begin
                        state_reg <= PSD_MDIX_LOCK;
                    end
                end
                PSD_MDIX_LOCK: begin
                    if (!auto_en_i) begin
                        state_reg <= PSD_MDIX_FORCED;
                    end else if (!rx_energy_i) begin
                        state_reg <= PSD_MDIX_HUNT;
                    end
                end
                PSD_MDIX_FORCED: begin
                    if (auto_en_i) begin
                        state_reg <= PSD_MDIX_HUNT;
                    end
                end
                default: begin
                    state_reg <= PSD_MDIX_HUNT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // slot timer runs only while hunting
    always_ff @(posedge clk_i) begin
        if (rst_i || state_reg != PSD_MDIX_HUNT || slot_end) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pair mapping: forced value when disabled, flipped per empty slot
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swap_o <= 1'b0;
        end else if (!auto_en_i) begin
            swap_o <= force_swap_i;
        end else if (state_reg == PSD_MDIX_HUNT && !rx_energy_i && slot_end) begin
            swap_o <= ~swap_o;
        end
    end

    // lock flag for status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            locked_o <= 1'b0;
        end else begin
            locked_o <= (state_reg == PSD_MDIX_LOCK);
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    property p_hunt_flip;
        @(posedge clk_i) disable iff (rst_i)
        (auto_en_i && state_reg == PSD_MDIX_HUNT && !rx_energy_i && slot_end)
            |=> (swap_o != $past(swap_o));
    endproperty
    a_hunt_flip: assert property (p_hunt_flip) else $error("pair map not flipped");

    property p_lock_hold;
        @(posedge clk_i) disable iff (rst_i)
        (auto_en_i && state_reg == PSD_MDIX_LOCK && rx_energy_i) ##1 auto_en_i
            |-> $stable(swap_o);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("pair map moved in lock");
endmodule

// File: psd_board_model.sv
// board side: strap resistors on shared pins, and the pins once the device drives them
module psd_board_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sup_i,
    input wire logic [4:0] addr_pd_i,
    input wire logic intsel_pd_i,
    input wire logic regoff_pu_i,
    input wire psd_pkg::psd_led_t led_i,
    input wire psd_pkg::psd_led_t led_oe_i,
    input wire logic crs_i,
    input wire logic crs_oe_i,
    output psd_pkg::psd_led_t led_pin_o,
    output logic crs_pin_o,
    output logic intsel_pin_o,
    output logic regoff_pin_o
);
    import psd_pkg::*;
    logic rel_reg; // reset seen low at an edge
    logic sup_reg; // supplies seen good since release
    logic tog_reg; // data pattern once pins are in use
    ////////////////////////////////////////////////////////////////
    // release tracking and pattern
    always_ff @(posedge clk_i) begin
        rel_reg <= !rst_i;
        sup_reg <= !rst_i & (sup_reg | sup_i);
        tog_reg <= rst_i ? 1'b0 : !tog_reg; // pattern starts from a known level
    end
    ////////////////////////////////////////////////////////////////
    // resolved pin levels: pull level unless driven
    assign led_pin_o = (led_oe_i & led_i) | (~led_oe_i & ~addr_pd_i[3:0]);
    assign crs_pin_o = crs_oe_i ? crs_i : !addr_pd_i[4];
    assign intsel_pin_o = rel_reg ? tog_reg : !intsel_pd_i;
    assign regoff_pin_o = sup_reg ? tog_reg : regoff_pu_i;
endmodule

// File: psd_top_tb.sv
`include "psd_defs.svh"
module psd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import psd_pkg::*;
    localparam int SLOT = 8; // short crossover slot
    logic clk_i, rst_i, cyc_i, stb_i, we_i, sup, anf, ans, tx, rx, rxe, irq, shp;
    logic [3:0] adr_i, sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic ack_o, crs_o, crs_oe_o, col_o, intl, shoe, tx4, regoff, full, spd, swap, done;
    logic crs_pin, intsel_pin, regoff_pin, ipd, rpu, s0;
    psd_led_t led_pin, lact, led_o, led_oe_o;
    psd_addr_t addr;
    logic [4:0] apd; // address pull-down mask
    int err_count, comparisons, n;
    psd_top #(.MDIX_SLOT_CYC(SLOT)) psd_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .led_pin_i(led_pin), .crs_pin_i(crs_pin),
        .shared_pin_function_strap_i(intsel_pin), .regulator_off_strap_pin_i(regoff_pin),
        .supplies_ok_i(sup), .an_full_duplex_i(anf), .an_speed_100_i(ans), .tx_active_i(tx),
        .rx_active_i(rx), .rx_energy_i(rxe), .irq_i(irq), .shared_pin_i(shp),
        .led_active_i(lact), .led_o(led_o), .led_oe_o(led_oe_o), .crs_o(crs_o),
        .crs_oe_o(crs_oe_o), .col_o(col_o), .interrupt_output_low_o(intl), .shared_oe_o(shoe),
        .transmit_symbol_bit_four_o(tx4), .regulator_off_o(regoff), .mgmt_addr_o(addr),
        .full_duplex_o(full), .speed_100_o(spd), .tx_pair_swap_o(swap), .straps_done_o(done));
    psd_board_model psd_board_model_i (.clk_i(clk_i), .rst_i(rst_i), .sup_i(sup),
        .addr_pd_i(apd), .intsel_pd_i(ipd), .regoff_pu_i(rpu), .led_i(led_o),
        .led_oe_i(led_oe_o), .crs_i(crs_o), .crs_oe_i(crs_oe_o), .led_pin_o(led_pin),
        .crs_pin_o(crs_pin), .intsel_pin_o(intsel_pin), .regoff_pin_o(regoff_pin));
    ////////////////////////////////////////////////////////////////
    // clock
    initial begin
        clk_i = 0;
        forever #5 clk_i = !clk_i;
    end
    // verdict and end of run
    task end_sim();
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // compare one value
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask
    // wait edges
    task cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    // one classic wishbone cycle, waits for ack
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int m;
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        m = 0;
        do begin
            @(posedge clk_i);
            m++;
        end while (ack_o !== 1'b1 && m < 50);
        if (m >= 50) chk("ack", 1, 0);
        r = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        we_i <= 0;
        @(posedge clk_i);
    endtask
    // reset pulse, straps come from the board model
    task do_rst();
        rst_i <= 1;
        cyc(2);
        chk("done rst", 0, done);
        rst_i <= 0;
        cyc(3);
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////
    // tests
    initial begin
        {rst_i, cyc_i, stb_i, we_i, sup, anf, ans, tx, rx, rxe, irq, shp} = 12'h800;
        adr_i = 0;
        sel_i = 4'hf;
        dat_i = 0;
        lact = 4'h3;
        apd = 5'h15;
        ipd = 1;
        rpu = 1;
        err_count = 0;
        comparisons = 0;
        // pulled-down function strap and some address straps, pulled-up regulator strap, supplies late
        do_rst();
        chk("addr", 5'h0a, addr);
        chk("done", 1, done);
        chk("crs oe", 1, crs_oe_o);
        chk("shoe", 0, shoe);
        shp <= 1;
        cyc(2);
        chk("tx4", 1, tx4);
        chk("led", 4'h9, led_o);
        chk("ledoe", 4'hf, led_oe_o);
        chk("regoff0", 0, regoff);
        sup <= 1;
        cyc(4);
        chk("regoff1", 1, regoff);
        cyc(20);
        wb(0, `PSD_STATUS_OFS, 0, q);
        chk("status", 32'h4a, q & 32'h7f);
        wb(1, `PSD_STATUS_OFS, 32'hffffffff, q);
        wb(0, `PSD_STATUS_OFS, 0, q);
        chk("status ro", 32'h4a, q & 32'h7f);
        chk("addr held", 5'h0a, addr);
        // floating straps
        apd <= 0;
        ipd <= 0;
        rpu <= 0;
        do_rst();
        chk("addr def", 5'h1f, addr);
        chk("shoe def", 1, shoe);
        irq <= 1;
        cyc(2);
        chk("int", 0, intl);
        chk("tx4 off", 0, tx4);
        chk("regoff def", 0, regoff);
        chk("led low", 4'hc, led_o);
        // duplex and carrier table
        wb(0, `PSD_CTRL_OFS, 0, q);
        chk("ctrl rst", `PSD_CTRL_RESET, q);
        for (int f = 0; f < 2; f++) begin
            wb(1, `PSD_CTRL_OFS, f ? 32'h2100 : 32'h0000, q);
            for (int k = 0; k < 4; k++) begin
                tx <= k[0];
                rx <= k[1];
                cyc(2);
                chk("crs", f ? k[1] : |k[1:0], crs_o);
                chk("col", f ? 0 : &k[1:0], col_o);
            end
            chk("full", f, full);
            chk("speed", f, spd);
        end
        anf <= 1;
        wb(1, `PSD_CTRL_OFS, 32'h1000, q);
        cyc(2);
        chk("an full", 1, full);
        chk("an speed", 0, spd);
        // crossover forced, hunting, locking
        wb(0, `PSD_MDIX_OFS, 0, q);
        chk("mdix rst", `PSD_MDIX_RESET, q);
        wb(1, `PSD_MDIX_OFS, 32'h3, q);
        cyc(3);
        chk("swap on", 1, swap);
        wb(1, `PSD_MDIX_OFS, 32'h1, q);
        cyc(3);
        chk("swap off", 0, swap);
        wb(1, `PSD_MDIX_OFS, 32'h0, q);
        cyc(3);
        n = 0;
        s0 = swap;
        repeat (4 * SLOT) begin
            @(posedge clk_i);
            if (swap !== s0) n++;
            s0 = swap;
        end
        chk("hunt", 4, n);
        rxe <= 1;
        cyc(4);
        chk("lock", 1, psd_top_i.mdix_locked);
        s0 = swap;
        cyc(3 * SLOT);
        chk("held", s0, swap);
        wb(0, `PSD_STATUS_OFS, 0, q);
        chk("st lock", 1, q[`PSD_ST_LOCK_BIT]);
        wb(0, 4'hc, 0, q);
        chk("unmapped", 0, q);
        end_sim();
    end
endmodule
